/* File: hdl/pressure_readout_defines.vh */
// Constants for the pressure sensor serial readout block.
`ifndef PRESSURE_READOUT_DEFINES_VH
`define PRESSURE_READOUT_DEFINES_VH

// ==========================================================================
// Register map (byte addresses)
`define REG_COEF_SENSITIVITY 8'h00
`define REG_COEF_OFFSET 8'h04
`define REG_COEF_SENS_TEMPCO 8'h08
`define REG_COEF_OFFSET_TEMPCO 8'h0C
`define REG_COEF_REF_TEMPERATURE 8'h10
`define REG_COEF_TEMP_SLOPE 8'h14
`define REG_RAW_PRESSURE 8'h18
`define REG_RAW_TEMPERATURE 8'h1C
`define REG_CONTROL 8'h20
`define REG_STATUS 8'h24
`define REG_CALIB_WORD_ONE 8'h28
`define REG_CALIB_WORD_TWO 8'h2C
`define REG_CALIB_WORD_THREE 8'h30
`define REG_CALIB_WORD_FOUR 8'h34

// ==========================================================================
// Field positions and reset values
`define CTRL_LOCK_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_STATE_LSB 4
`define STAT_LOCK_BIT 8
`define RESULT_RESET 16'h0000

// ==========================================================================
// Serial framing
`define START_BITS 3'h7
`define STOP_BITS 3'h0
`define SEL_CONV_PRESSURE 4'hA
`define SEL_CONV_TEMPERATURE 4'h9
`define SEL_CALIB_ONE 4'h5
`define SEL_CALIB_TWO 4'h6
`define SEL_CALIB_THREE 4'h3
`define SEL_CALIB_FOUR 4'hC
`define RESYNC_PATTERN 21'h155540
`define ACK_EXTRA_CLOCKS 2'h2
`define READOUT_CLOCKS 5'h11

// ==========================================================================
// Timing
`define REF_CLK_PERIOD_NS 5
`define CONV_TIME_MS 35

`endif

/* File: hdl/pressure_sensor_serial_readout.v */
// Serial command decoder, conversion sequencer and result shifter of the sensor.
`timescale 1ns/1ps
`default_nettype none
`include "pressure_readout_defines.vh"
module pressure_sensor_serial_readout #(
  parameter CONV_CYCLES = `CONV_TIME_MS * 1000000 / `REF_CLK_PERIOD_NS
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_sclk,
  input wire i_din,
  output reg o_dout,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata
);

  // ========================================================================
  // States and local widths
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CONV = 3'h1;
  localparam [2:0] ST_EOC = 3'h2;
  localparam [2:0] ST_SHIFT = 3'h3;
  localparam CNT_W = 24;

  reg [2:0] state;
  reg sclk_s1;
  reg sclk_s2;
  reg sclk_s3;
  reg din_s1;
  reg din_s2;
  reg [20:0] resync_hist;
  reg [9:0] cmd_hist;
  reg [1:0] ack_cnt;
  reg [CNT_W-1:0] conv_cnt;
  reg conv_is_temp;
  reg [15:0] shreg;
  reg [4:0] bit_cnt;
  reg [12:0] coef_sensitivity;
  reg [12:0] coef_offset;
  reg [9:0] coef_sens_tempco;
  reg [8:0] coef_offset_tempco;
  reg [11:0] coef_ref_temperature;
  reg [6:0] coef_temp_slope;
  reg [15:0] raw_pressure_result;
  reg [15:0] raw_temperature_result;
  reg otp_locked;

  wire sclk_rise;
  wire [20:0] next_resync_hist;
  wire [9:0] next_cmd_hist;
  wire [3:0] sel;
  wire cmd_framed;
  wire conv_done;
  wire [15:0] calib_word_one;
  wire [15:0] calib_word_two;
  wire [15:0] calib_word_three;
  wire [15:0] calib_word_four;

  // ========================================================================
  // Word packing
  function [15:0] pack_word;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: pack_word = {coef_sensitivity, coef_offset[12:10]};
        2'h1: pack_word = {coef_offset[9:0], coef_ref_temperature[11:6]};
        2'h2: pack_word = {coef_sens_tempco, coef_ref_temperature[5:0]};
        default: pack_word = {coef_offset_tempco, coef_temp_slope};
      endcase
    end
  endfunction

  assign calib_word_one = pack_word(2'h0);
  assign calib_word_two = pack_word(2'h1);
  assign calib_word_three = pack_word(2'h2);
  assign calib_word_four = pack_word(2'h3);

  // ========================================================================
  // Pin synchronisers
  // The third shift clock stage exists only for edge detection, so the
  // first stage feeds nothing but the second.
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else if (i_ce) begin
      sclk_s1 <= i_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      din_s1 <= i_din;
      din_s2 <= din_s1;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign next_resync_hist = {resync_hist[19:0], din_s2};
  assign next_cmd_hist = {cmd_hist[8:0], din_s2};
  assign sel = next_cmd_hist[6:3];
  assign cmd_framed = (next_cmd_hist[9:7] == `START_BITS) &&
                      (next_cmd_hist[2:0] == `STOP_BITS);
  assign conv_done = (conv_cnt == CONV_CYCLES[CNT_W-1:0]);

  // ========================================================================
  // Protocol engine
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_IDLE;
      resync_hist <= 21'h000000;
      cmd_hist <= 10'h000;
      ack_cnt <= 2'h0;
      conv_cnt <= {CNT_W{1'b0}};
      conv_is_temp <= 1'b0;
      shreg <= `RESULT_RESET;
      bit_cnt <= 5'h00;
      o_dout <= 1'b0;
    end else if (i_ce) begin
      if (sclk_rise) begin
        resync_hist <= next_resync_hist;
      end
      // The resync pattern is watched in every state; the output may have
      // moved while it was arriving, which the host must tolerate.
      if (sclk_rise && next_resync_hist == `RESYNC_PATTERN) begin
        state <= ST_IDLE;
        cmd_hist <= 10'h000;
        ack_cnt <= 2'h0;
        conv_cnt <= {CNT_W{1'b0}};
        bit_cnt <= 5'h00;
        o_dout <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (sclk_rise) begin
              cmd_hist <= next_cmd_hist;
              if (cmd_framed) begin
                cmd_hist <= 10'h000;
                bit_cnt <= 5'h00;
                if (sel == `SEL_CONV_PRESSURE || sel == `SEL_CONV_TEMPERATURE) begin
                  conv_is_temp <= (sel == `SEL_CONV_TEMPERATURE);
                  conv_cnt <= {CNT_W{1'b0}};
                  ack_cnt <= 2'h0;
                  o_dout <= 1'b1;
                  state <= ST_CONV;
                end else if (sel == `SEL_CALIB_ONE) begin
                  shreg <= calib_word_one;
                  state <= ST_SHIFT;
                end else if (sel == `SEL_CALIB_TWO) begin
                  shreg <= calib_word_two;
                  state <= ST_SHIFT;
                end else if (sel == `SEL_CALIB_THREE) begin
                  shreg <= calib_word_three;
                  state <= ST_SHIFT;
                end else if (sel == `SEL_CALIB_FOUR) begin
                  shreg <= calib_word_four;
                  state <= ST_SHIFT;
                end
              end
            end
          end
          ST_CONV: begin
            // Only one conversion can run: commands are decoded in idle only.
            if (!conv_done) begin
              conv_cnt <= conv_cnt + 1'b1;
            end
            if (sclk_rise && ack_cnt != `ACK_EXTRA_CLOCKS) begin
              ack_cnt <= ack_cnt + 1'b1;
            end
            if (conv_done && ack_cnt == `ACK_EXTRA_CLOCKS) begin
              o_dout <= 1'b0;
              shreg <= conv_is_temp ? raw_temperature_result : raw_pressure_result;
              bit_cnt <= 5'h00;
              state <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            // Nothing moves without an edge, so a held clock pauses readout.
            if (sclk_rise) begin
              bit_cnt <= bit_cnt + 1'b1;
              if (bit_cnt == `READOUT_CLOCKS - 5'h01) begin
                o_dout <= 1'b0;
                state <= ST_IDLE;
              end else begin
                o_dout <= shreg[15];
                shreg <= {shreg[14:0], 1'b0};
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            o_dout <= 1'b0;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Register file
  // The coefficient store behaves as one-time memory: once locked, writes
  // to it are dropped until the next reset.
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      coef_sensitivity <= 13'h0000;
      coef_offset <= 13'h0000;
      coef_sens_tempco <= 10'h000;
      coef_offset_tempco <= 9'h000;
      coef_ref_temperature <= 12'h000;
      coef_temp_slope <= 7'h00;
      raw_pressure_result <= `RESULT_RESET;
      raw_temperature_result <= `RESULT_RESET;
      otp_locked <= 1'b0;
    end else if (i_ce && i_wr) begin
      if (i_addr == `REG_COEF_SENSITIVITY && !otp_locked) begin
        coef_sensitivity <= i_wdata[12:0];
      end else if (i_addr == `REG_COEF_OFFSET && !otp_locked) begin
        coef_offset <= i_wdata[12:0];
      end else if (i_addr == `REG_COEF_SENS_TEMPCO && !otp_locked) begin
        coef_sens_tempco <= i_wdata[9:0];
      end else if (i_addr == `REG_COEF_OFFSET_TEMPCO && !otp_locked) begin
        coef_offset_tempco <= i_wdata[8:0];
      end else if (i_addr == `REG_COEF_REF_TEMPERATURE && !otp_locked) begin
        coef_ref_temperature <= i_wdata[11:0];
      end else if (i_addr == `REG_COEF_TEMP_SLOPE && !otp_locked) begin
        coef_temp_slope <= i_wdata[6:0];
      end else if (i_addr == `REG_RAW_PRESSURE) begin
        raw_pressure_result <= i_wdata[15:0];
      end else if (i_addr == `REG_RAW_TEMPERATURE) begin
        raw_temperature_result <= i_wdata[15:0];
      end else if (i_addr == `REG_CONTROL) begin
        otp_locked <= otp_locked | i_wdata[`CTRL_LOCK_BIT];
      end
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 32'h00000000;
    end else if (i_ce) begin
      o_rdata <= 32'h00000000;
      if (i_rd) begin
        if (i_addr == `REG_COEF_SENSITIVITY) begin
          o_rdata <= {19'h00000, coef_sensitivity};
        end else if (i_addr == `REG_COEF_OFFSET) begin
          o_rdata <= {19'h00000, coef_offset};
        end else if (i_addr == `REG_COEF_SENS_TEMPCO) begin
          o_rdata <= {22'h000000, coef_sens_tempco};
        end else if (i_addr == `REG_COEF_OFFSET_TEMPCO) begin
          o_rdata <= {23'h000000, coef_offset_tempco};
        end else if (i_addr == `REG_COEF_REF_TEMPERATURE) begin
          o_rdata <= {20'h00000, coef_ref_temperature};
        end else if (i_addr == `REG_COEF_TEMP_SLOPE) begin
          o_rdata <= {25'h0000000, coef_temp_slope};
        end else if (i_addr == `REG_RAW_PRESSURE) begin
          o_rdata <= {16'h0000, raw_pressure_result};
        end else if (i_addr == `REG_RAW_TEMPERATURE) begin
          o_rdata <= {16'h0000, raw_temperature_result};
        end else if (i_addr == `REG_CONTROL) begin
          o_rdata <= {31'h00000000, otp_locked};
        end else if (i_addr == `REG_STATUS) begin
          o_rdata <= {23'h000000, otp_locked, 1'b0, state, 3'h0, (state == ST_CONV)};
        end else if (i_addr == `REG_CALIB_WORD_ONE) begin
          o_rdata <= {16'h0000, calib_word_one};
        end else if (i_addr == `REG_CALIB_WORD_TWO) begin
          o_rdata <= {16'h0000, calib_word_two};
        end else if (i_addr == `REG_CALIB_WORD_THREE) begin
          o_rdata <= {16'h0000, calib_word_three};
        end else if (i_addr == `REG_CALIB_WORD_FOUR) begin
          o_rdata <= {16'h0000, calib_word_four};
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: sim/pressure_readout_checker.sv */
// Port-level assertions for the sensor serial readout block.
`timescale 1ns/1ps
`default_nettype none
// ====
// Checker
module pressure_readout_checker #(
  parameter CONV_CYCLES = 50
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_din,
  input wire logic o_dout,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // The output may only rise while the host holds the shift clock high.
  AST_DOUT_RISE_SCLK: assert property ($rose(o_dout) |-> i_sclk)
    else $error("serial output rose while shift clock low");
  // With the clock parked for eight cycles the output may only hold or fall.
  AST_DOUT_HOLD: assert property ((!i_sclk) [*8] |-> $stable(o_dout) || $fell(o_dout))
    else $error("serial output moved while shift clock parked");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  AST_UNMAPPED: assert property (i_rd && i_addr > 8'h34 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_WORD_UPPER: assert property (i_rd && i_addr >= 8'h28 && i_addr <= 8'h34
    |=> o_rdata[31:16] == 16'h0)
    else $error("calibration word wider than sixteen bits");
  AST_RAW_READBACK: assert property (i_wr && i_addr == 8'h18 ##1 i_rd && i_addr == 8'h18
    |=> o_rdata == ($past(i_wdata, 2) & 32'h0000FFFF))
    else $error("raw result readback wrong");
  AST_WORD_ONE: assert property (i_wr && i_addr == 8'h00 ##1 i_rd && i_addr == 8'h28
    |=> ((o_rdata >> 3) & 32'h1FFF) == ($past(i_wdata, 2) & 32'h1FFF))
    else $error("first coefficient misplaced in word one");
  AST_WORD_FOUR: assert property (i_wr && i_addr == 8'h14 ##1 i_rd && i_addr == 8'h34
    |=> (o_rdata & 32'h7F) == ($past(i_wdata, 2) & 32'h7F))
    else $error("sixth coefficient misplaced in word four");
endmodule
bind pressure_sensor_serial_readout pressure_readout_checker #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_sclk(i_sclk), .i_din(i_din),
  .o_dout(o_dout), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata));
`default_nettype wire

/* File: sim/pressure_sensor_serial_readout_bench.sv */
// Self-checking bench for the sensor serial readout block.
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module pressure_sensor_serial_readout_bench;
  localparam [12:0] C1 = 13'h1ABC;
  localparam [12:0] C2 = 13'h0F35;
  localparam [9:0] C3 = 10'h2D1;
  localparam [8:0] C4 = 9'h1A5;
  localparam [11:0] C5 = 12'hB6C;
  localparam [6:0] C6 = 7'h5A;
  localparam [15:0] RP = 16'hA5C3;
  localparam [15:0] RT = 16'h3C96;
  logic i_ref_clk, i_rst_b, i_ce, i_wr, i_rd;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  wire sclk, din, dout;
  wire [31:0] rdata;
  logic [15:0] words [4];
  logic [3:0] sels [4];
  int failures, samples_checked, k, n;
  pressure_sensor_serial_readout #(.CONV_CYCLES(50)) dut (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_ce(i_ce), .i_sclk(sclk), .i_din(din), .o_dout(dout),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata));
  sensor_host_model host (.o_sclk(sclk), .o_din(din), .i_dout(dout));
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    #1 check(rdata, exp);
  endtask
  task test_done();
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // A hang costs one mismatch; the whole run needs well under this span.
  initial begin
    #100000;
    failures++;
    test_done();
  end
  initial begin
    {i_rst_b, i_wr, i_rd, i_addr, i_wdata} = 0;
    i_ce = 1'b1;
    words[0] = {C1, C2[12:10]};
    words[1] = {C2[9:0], C5[11:6]};
    words[2] = {C3, C5[5:0]};
    words[3] = {C4, C6};
    sels = '{4'h5, 4'h6, 4'h3, 4'hC};
    repeat (8) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    bus(1'b1, 1'b0, 8'h04, 32'(C2));
    bus(1'b1, 1'b0, 8'h08, 32'(C3));
    bus(1'b1, 1'b0, 8'h0C, 32'(C4));
    bus(1'b1, 1'b0, 8'h10, 32'(C5));
    bus(1'b1, 1'b0, 8'h00, 32'(C1));
    bus(1'b0, 1'b1, 8'h28, 32'h0);
    bus(1'b1, 1'b0, 8'h14, 32'(C6));
    bus(1'b0, 1'b1, 8'h34, 32'h0);
    bus(1'b1, 1'b0, 8'h18, 32'(RP));
    bus(1'b0, 1'b1, 8'h18, 32'h0);
    bus(1'b1, 1'b0, 8'h1C, 32'(RT));
    for (k = 0; k < 4; k++) rd_chk(8'h28 + 8'(k * 4), {16'h0, words[k]});
    rd_chk(8'h1C, {16'h0, RT});
    rd_chk(8'h40, 32'h0);
    // A write made while the clock enable is low must be lost.
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    bus(1'b1, 1'b0, 8'h18, 32'h0000FFFF);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    @(posedge i_ref_clk);
    i_ce <= 1'b1;
    rd_chk(8'h18, {16'h0, RP});
    for (k = 0; k < 4; k++) begin
      host.cmd(sels[k]);
      host.rx(17);
      check(32'(host.acc), {15'h0, words[k], 1'b0});
    end
    for (k = 0; k < 2; k++) begin
      host.resync();
      host.cmd(k ? 4'h9 : 4'hA);
      check(32'(dout), 32'h1);
      rd_chk(8'h24, 32'h11);
      host.tx(21'h0, 2);
      n = 0;
      while (dout !== 1'b0 && n < 400) begin
        @(posedge i_ref_clk);
        n++;
      end
      check(32'(dout), 32'h0);
      host.rx(5);
      #500;
      host.rx(12);
      check(32'(host.acc), {15'h0, k ? RT : RP, 1'b0});
    end
    host.cmd(4'hF);
    host.rx(17);
    check(32'(host.acc), 32'h0);
    host.cmd(4'h5);
    host.rx(6);
    host.resync();
    check(32'(dout), 32'h0);
    host.cmd(4'h6);
    host.rx(17);
    check(32'(host.acc), {15'h0, words[1], 1'b0});
    bus(1'b1, 1'b0, 8'h20, 32'h1);
    bus(1'b1, 1'b0, 8'h00, 32'h0);
    rd_chk(8'h00, {19'h0, C1});
    rd_chk(8'h24, 32'h100);
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rd_chk(8'h20, 32'h0);
    rd_chk(8'h00, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire

/* File: sim/sensor_host_model.sv */
// Host-side serial master that owns the shift clock and frames commands.
`timescale 1ns/1ps
`default_nettype none
// ====
// Host model
module sensor_host_model (
  output var logic o_sclk,
  output var logic o_din,
  input wire logic i_dout
);
  logic [16:0] acc;
  initial begin
    o_sclk = 1'b0;
    o_din = 1'b0;
    acc = 17'h0;
  end
  // Data change at the falling edge; the clock rests low between frames.
  task tx(input logic [20:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      o_din = bits[i];
      #32 o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
    end
  endtask
  task cmd(input logic [3:0] sel);
    tx({11'h0, 3'h7, sel, 3'h0}, 10);
  endtask
  // The output is not looked at here since it may toggle meanwhile.
  task resync();
    tx(21'h155540, 21);
  endtask
  // Sampled on each falling edge; callers may park the clock between calls.
  task rx(input int n);
    for (int i = 0; i < n; i++) begin
      #32 o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
      acc = {acc[15:0], i_dout};
    end
  endtask
endmodule
`default_nettype wire
